// file: rtl/aosq_top.sv
`timescale 1ns/10ps
// How it works
// - Output holds zero-volt code after reset
// - One bipolar ten-volt channel, gain fixed
// - Sample words fixed at 24 bits
// - Base variant paces at fixed 46.875 kHz
// - Extended variant accepts 10 to 52.734 kHz
// - Oscillator runs at rate times 512
// - Timebase capped at 24 or 27 MHz
// - First output after 34 or 29 ticks
// - Single value goes out at once
// - Single value ends itself, no stop
// - Base: error if input already running
// - Base FIFO 8192; larger buffer errors
// - Waveform: paced output from loaded FIFO
// - Waveform wraps to first entry forever
// - Base: output must start before input
// - Continuous: wait trigger if external edge selected, paced queue output
// - Empty queue while running flags underrun, except in continuous orderly stop
// - Buffers gap-free; stop when data ends
// - Orderly stop: finish count then halt
// - Abrupt stop halts at once
// - Start by command, or by external edge in continuous mode only
// - Codes are offset binary
module aosq_top
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_trig,
  input  wire logic        ai_running,
  output logic [23:0]      dac_code,
  output logic             dac_osc,
  output logic             dac_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned FA = aosq_pkg::FIFO_AW;

  typedef struct packed {
    aosq_pkg::aosq_state_t  state;
    logic        rdy;
    logic [31:0] rdata;
    logic        repeat_one_buffer;
    logic        ext_sel;
    logic        extended;
    logic [23:0] rate;
    logic [31:0] step;
    logic [23:0] code;
    logic [13:0] len;
    logic [FA-1:0] wptr;
    logic [FA-1:0] rptr;
    logic [13:0] level;
    logic [31:0] remain;
    logic        orderly;
    logic [5:0]  lat;
    logic        trig_d;
    logic        strobe;
    logic        err_ai;
    logic        err_size;
    logic        err_rate;
    logic        underrun;
    logic        done;
  } aosq_st_t;

  aosq_st_t    st_ff;
  aosq_st_t    nxt_st;
  logic [23:0] mem_ff [aosq_pkg::FIFO_DEPTH];
  logic        osc_tick;
  logic        sample_tick;
  logic        pace_run;
  logic        wr_acc;
  logic        rd_acc;
  logic        mem_we;

  ////////////////////////////////////////////////////////////////////////////
  // Step = rate * 512 * 2^32 / 50e6 = rate * 2^41 / 50e6
  function automatic logic [31:0] rate_step(input logic [23:0] r);
    logic [63:0] p;
    p = ({40'h0, r} << 41) / 64'd50000000;
    return p[31:0];
  endfunction : rate_step

  function automatic logic rate_ok(input logic [23:0] r, input logic ext);
    if (!ext)
      return r == 24'(aosq_pkg::BASE_RATE_HZ);
    return (r >= 24'(aosq_pkg::EXT_RATE_MIN_HZ)) &&
           (r <= 24'(aosq_pkg::EXT_RATE_MAX_HZ)) &&
           ({8'h0, r} * 32'(aosq_pkg::OSC_MULT) <= 32'(aosq_pkg::EXT_TB_MAX_HZ));
  endfunction : rate_ok

  assign pace_run = (st_ff.state == aosq_pkg::AOSQ_LATENCY) ||
                    (st_ff.state == aosq_pkg::AOSQ_RUN) ||
                    (st_ff.state == aosq_pkg::AOSQ_DRAIN);

  aosq_pacer u_pacer
  (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .run         (pace_run),
    .step        (st_ff.step),
    .osc_tick    (osc_tick),
    .sample_tick (sample_tick)
  );

  assign wr_acc = avs_write && !st_ff.rdy;
  assign rd_acc = avs_read && !st_ff.rdy;
  assign mem_we = wr_acc && (avs_address == aosq_pkg::REG_DATA) &&
                  (st_ff.level < 14'(aosq_pkg::FIFO_DEPTH)) &&
                  (st_ff.state != aosq_pkg::AOSQ_IDLE || !st_ff.repeat_one_buffer ||
                   st_ff.wptr < st_ff.len[FA-1:0] || st_ff.len == 14'h0 ||
                   st_ff.len == 14'(aosq_pkg::FIFO_DEPTH));

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic        pop;
    logic        push;
    logic        start;
    logic        trig_edge;
    logic        any_err;
    logic [23:0] nrate;
    pop       = 1'b0;
    push      = mem_we;
    start     = 1'b0;
    any_err   = 1'b0;
    nrate     = st_ff.rate;
    trig_edge = ext_trig && !st_ff.trig_d;
    nxt_st    = st_ff;
    nxt_st.trig_d = ext_trig;
    nxt_st.strobe = 1'b0;
    nxt_st.rdy    = avs_read || avs_write ? !st_ff.rdy : 1'b0;
    if (rd_acc)
    begin
      case (avs_address)
        aosq_pkg::REG_CTRL:   nxt_st.rdata = {25'h0, st_ff.extended, 1'b0, st_ff.ext_sel,
                                              st_ff.repeat_one_buffer, 3'h0};
        aosq_pkg::REG_RATE:   nxt_st.rdata = {8'h0, st_ff.rate};
        aosq_pkg::REG_LENGTH: nxt_st.rdata = {18'h0, st_ff.len};
        aosq_pkg::REG_COUNT:  nxt_st.rdata = st_ff.remain;
        aosq_pkg::REG_STATUS: nxt_st.rdata = {10'h0, st_ff.level, st_ff.done,
                                              st_ff.underrun, st_ff.err_rate, st_ff.err_size,
                                              st_ff.err_ai, st_ff.state};
        aosq_pkg::REG_OUT:    nxt_st.rdata = {8'h0, st_ff.code};
        default:              nxt_st.rdata = 32'h0;
      endcase
    end
    if (wr_acc)
    begin
      case (avs_address)
        aosq_pkg::REG_CTRL:
        begin
          if (avs_writedata[aosq_pkg::CTL_CLRERR])
          begin
            nxt_st.err_ai   = 1'b0;
            nxt_st.err_size = 1'b0;
            nxt_st.err_rate = 1'b0;
            nxt_st.underrun = 1'b0;
            nxt_st.done     = 1'b0;
          end
          if (st_ff.state == aosq_pkg::AOSQ_IDLE)
          begin
            nxt_st.repeat_one_buffer = avs_writedata[aosq_pkg::CTL_REPEAT];
            nxt_st.ext_sel  = avs_writedata[aosq_pkg::CTL_EXTTRIG] &&
                              avs_writedata[aosq_pkg::CTL_EXTENDED] &&
                              !avs_writedata[aosq_pkg::CTL_REPEAT];
            nxt_st.extended = avs_writedata[aosq_pkg::CTL_EXTENDED];
            start = avs_writedata[aosq_pkg::CTL_START];
          end
          if (avs_writedata[aosq_pkg::CTL_ABRUPT] && st_ff.state != aosq_pkg::AOSQ_IDLE)
          begin
            nxt_st.state = aosq_pkg::AOSQ_IDLE;
            nxt_st.level = 14'h0;
            nxt_st.wptr  = '0;
            nxt_st.rptr  = '0;
            push = 1'b0;
          end
          else if (avs_writedata[aosq_pkg::CTL_ORDERLY] &&
                   st_ff.state != aosq_pkg::AOSQ_IDLE)
          begin
            nxt_st.orderly = 1'b1;
          end
        end
        aosq_pkg::REG_RATE:
        begin
          nrate = avs_writedata[23:0];
          if (st_ff.state == aosq_pkg::AOSQ_IDLE)
            nxt_st.rate = nrate;
        end
        aosq_pkg::REG_VALUE:
        begin
          if (ai_running && !st_ff.extended)
            nxt_st.err_ai = 1'b1;
          else if (st_ff.state == aosq_pkg::AOSQ_IDLE)
            nxt_st.code = avs_writedata[23:0];
        end
        aosq_pkg::REG_LENGTH:
        begin
          if (st_ff.state == aosq_pkg::AOSQ_IDLE)
            nxt_st.len = avs_writedata[13:0];
          if (!st_ff.extended && avs_writedata[31:0] > 32'(aosq_pkg::FIFO_DEPTH))
            nxt_st.err_size = 1'b1;
        end
        aosq_pkg::REG_COUNT:  nxt_st.remain = avs_writedata;
        default:              nxt_st.remain = nxt_st.remain;
      endcase
    end
    if (start)
    begin
      // Variant bit of this same write governs the start
      if (ai_running && !nxt_st.extended)
        nxt_st.err_ai = 1'b1;
      else if (!nxt_st.extended && st_ff.len > 14'(aosq_pkg::FIFO_DEPTH))
        nxt_st.err_size = 1'b1;
      else if (!rate_ok(nxt_st.extended ? st_ff.rate : 24'(aosq_pkg::BASE_RATE_HZ),
                        nxt_st.extended))
        nxt_st.err_rate = 1'b1;
      else if (!nxt_st.extended && !avs_writedata[aosq_pkg::CTL_REPEAT])
        nxt_st.err_rate = 1'b1; // Continuous needs extended variant
      else
      begin
        nxt_st.step = rate_step(nxt_st.extended ? st_ff.rate :
                                24'(aosq_pkg::BASE_RATE_HZ));
        nxt_st.orderly = 1'b0;
        nxt_st.done    = 1'b0;
        nxt_st.lat     = nxt_st.extended ? 6'(aosq_pkg::EXT_LATENCY) :
                                           6'(aosq_pkg::BASE_LATENCY);
        nxt_st.state   = nxt_st.ext_sel ? aosq_pkg::AOSQ_ARMED :
                                          aosq_pkg::AOSQ_LATENCY;
      end
    end
    case (st_ff.state)
      aosq_pkg::AOSQ_IDLE:    nxt_st.lat = nxt_st.lat;
      aosq_pkg::AOSQ_ARMED:
        if (trig_edge && nxt_st.state == aosq_pkg::AOSQ_ARMED)
          nxt_st.state = aosq_pkg::AOSQ_LATENCY;
      aosq_pkg::AOSQ_LATENCY:
        if (sample_tick && nxt_st.state == aosq_pkg::AOSQ_LATENCY)
        begin
          if (st_ff.lat == 6'h1)
            nxt_st.state = aosq_pkg::AOSQ_RUN;
          nxt_st.lat = st_ff.lat - 6'h1;
        end
      aosq_pkg::AOSQ_RUN, aosq_pkg::AOSQ_DRAIN:
        if (sample_tick && nxt_st.state != aosq_pkg::AOSQ_IDLE)
        begin
          if (st_ff.orderly && st_ff.remain == 32'h0)
          begin
            nxt_st.state = aosq_pkg::AOSQ_IDLE;
            nxt_st.done  = 1'b1;
            any_err      = 1'b1; // Halted: flush stale queue
          end
          else if (st_ff.level == 14'h0)
          begin
            nxt_st.state = aosq_pkg::AOSQ_IDLE;
            if (st_ff.repeat_one_buffer || !st_ff.orderly)
              nxt_st.underrun = 1'b1;
            any_err = 1'b1;
          end
          else
          begin
            nxt_st.code   = mem_ff[st_ff.rptr];
            nxt_st.strobe = 1'b1;
            if (st_ff.orderly)
              nxt_st.remain = st_ff.remain - 32'h1;
            if (st_ff.repeat_one_buffer)
              nxt_st.rptr = (st_ff.rptr == st_ff.len[FA-1:0] - FA'(1) ||
                             st_ff.len == 14'h0) ? '0 : st_ff.rptr + FA'(1);
            else
            begin
              nxt_st.rptr = st_ff.rptr + FA'(1);
              pop = 1'b1;
            end
          end
        end
      default: nxt_st.state = aosq_pkg::AOSQ_IDLE;
    endcase
    if (push)
      nxt_st.wptr = st_ff.wptr + FA'(1);
    if (push && !pop)
      nxt_st.level = st_ff.level + 14'h1;
    else if (pop && !push)
      nxt_st.level = st_ff.level - 14'h1;
    if (any_err)
    begin
      nxt_st.wptr  = '0;
      nxt_st.rptr  = '0;
      nxt_st.level = 14'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_ff       <= '0;
      st_ff.code  <= aosq_pkg::ZERO_VOLT_CODE;
      st_ff.rate  <= aosq_pkg::BASE_RATE_RESET;
      st_ff.state <= aosq_pkg::AOSQ_IDLE;
    end
    else
      st_ff <= nxt_st;
  end

  always_ff @(posedge sys_clk)
  begin
    if (mem_we)
      mem_ff[st_ff.wptr] <= avs_writedata[23:0];
  end

  assign avs_waitrequest = (avs_read || avs_write) && !st_ff.rdy;
  assign avs_readdata    = st_ff.rdata;
  assign dac_code        = st_ff.code;
  assign dac_osc         = osc_tick;
  assign dac_strobe      = st_ff.strobe;

  ////////////////////////////////////////////////////////////////////////////
  a_reset_zero_volt: assert property (@(posedge sys_clk)
    srst |=> dac_code == 24'h800000) else $error("output not zero volt after reset");
  a_strobe_only_run: assert property (@(posedge sys_clk) disable iff (srst)
    dac_strobe |-> $past(st_ff.state) == aosq_pkg::AOSQ_RUN ||
                   $past(st_ff.state) == aosq_pkg::AOSQ_DRAIN)
    else $error("sample emitted outside run");
  a_abrupt_halts: assert property (@(posedge sys_clk) disable iff (srst)
    wr_acc && avs_address == 6'h00 && avs_writedata[2] && st_ff.state != 0
    |=> st_ff.state == aosq_pkg::AOSQ_IDLE && !dac_strobe)
    else $error("abrupt stop did not halt");
  a_base_ai_error: assert property (@(posedge sys_clk) disable iff (srst)
    wr_acc && avs_address == 6'h08 && ai_running && !st_ff.extended
    |=> st_ff.err_ai && $stable(dac_code)) else $error("input conflict not flagged");
  a_single_value: assert property (@(posedge sys_clk) disable iff (srst)
    wr_acc && avs_address == 6'h08 && !ai_running && st_ff.state == 0
    |=> dac_code == $past(avs_writedata[23:0])) else $error("single value not output");
  a_size_error: assert property (@(posedge sys_clk) disable iff (srst)
    wr_acc && avs_address == 6'h0C && !st_ff.extended && avs_writedata > 32'd8192
    |=> st_ff.err_size) else $error("oversize buffer not flagged");
  a_underrun_flag: assert property (@(posedge sys_clk) disable iff (srst)
    sample_tick && st_ff.state == aosq_pkg::AOSQ_RUN && st_ff.level == 0 &&
    !st_ff.orderly && !wr_acc |=> st_ff.underrun && st_ff.state == aosq_pkg::AOSQ_IDLE)
    else $error("underrun not flagged");
  a_wrap_pointer: assert property (@(posedge sys_clk) disable iff (srst)
    dac_strobe && st_ff.repeat_one_buffer |-> st_ff.rptr < st_ff.len[FA-1:0] ||
    st_ff.len == 0 || st_ff.len == 14'd8192) else $error("read pointer past buffer");
  a_armed_waits: assert property (@(posedge sys_clk) disable iff (srst)
    st_ff.state == aosq_pkg::AOSQ_ARMED && !(ext_trig && !st_ff.trig_d) && !wr_acc
    |=> st_ff.state == aosq_pkg::AOSQ_ARMED) else $error("left armed without trigger");
  a_timebase_cap: assert property (@(posedge sys_clk) disable iff (srst)
    pace_run |-> st_ff.step <= 32'd2319282340) else $error("timebase over limit");

  c_waveform: cover property (@(posedge sys_clk) dac_strobe && st_ff.repeat_one_buffer);
  c_continuous: cover property (@(posedge sys_clk) dac_strobe && !st_ff.repeat_one_buffer);
  c_underrun: cover property (@(posedge sys_clk) $rose(st_ff.underrun));
  c_orderly_done: cover property (@(posedge sys_clk) $rose(st_ff.done));

endmodule : aosq_top

// file: rtl/aosq_pkg.sv
package aosq_pkg;

  localparam int unsigned SYS_CLK_HZ       = 50000000;
  localparam int unsigned DAC_BITS         = 24;
  localparam int unsigned OSC_MULT         = 512;
  localparam int unsigned BASE_RATE_HZ     = 46875;
  localparam int unsigned EXT_RATE_MIN_HZ  = 10000;
  localparam int unsigned EXT_RATE_MAX_HZ  = 52734;
  localparam int unsigned BASE_TB_MAX_HZ   = 24000000;
  localparam int unsigned EXT_TB_MAX_HZ    = 27000000;
  localparam int unsigned BASE_LATENCY     = 34;
  localparam int unsigned EXT_LATENCY      = 29;
  localparam int unsigned FIFO_DEPTH       = 8192;
  localparam int unsigned FIFO_AW          = 13;

  // Phase accumulator: step = rate * 512 * 2^32 / clk, wraps 32 bits
  localparam int unsigned ACC_W            = 32;

  localparam logic [23:0] ZERO_VOLT_CODE   = 24'h800000;
  localparam logic [23:0] BASE_RATE_RESET  = 24'h00B71B;

  // Register map, byte addresses
  localparam logic [5:0] REG_CTRL          = 6'h00;
  localparam logic [5:0] REG_RATE          = 6'h04;
  localparam logic [5:0] REG_VALUE         = 6'h08;
  localparam logic [5:0] REG_LENGTH        = 6'h0C;
  localparam logic [5:0] REG_DATA          = 6'h10;
  localparam logic [5:0] REG_COUNT         = 6'h14;
  localparam logic [5:0] REG_STATUS        = 6'h18;
  localparam logic [5:0] REG_OUT           = 6'h1C;

  // CTRL bits
  localparam int unsigned CTL_START        = 0;
  localparam int unsigned CTL_ORDERLY      = 1;
  localparam int unsigned CTL_ABRUPT       = 2;
  localparam int unsigned CTL_REPEAT       = 3;
  localparam int unsigned CTL_EXTTRIG      = 4;
  localparam int unsigned CTL_CLRERR       = 5;
  localparam int unsigned CTL_EXTENDED     = 6;

  typedef enum logic [2:0] {
    AOSQ_IDLE    = 3'b000,
    AOSQ_ARMED   = 3'b001,
    AOSQ_LATENCY = 3'b010,
    AOSQ_RUN     = 3'b011,
    AOSQ_DRAIN   = 3'b100
  } aosq_state_t;

endpackage : aosq_pkg

// file: rtl/aosq_pacer.sv
`timescale 1ns/10ps
// Sample tick generator: 512x oscillator then divide by 512
module aosq_pacer
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        run,
  input  wire logic [31:0] step,
  output logic             osc_tick,
  output logic             sample_tick
);

  typedef struct packed {
    logic [31:0] acc;
    logic [8:0]  div;
    logic        osc;
    logic        smp;
  } aosq_pace_t;

  aosq_pace_t st_ff;
  aosq_pace_t nxt_st;

  always_comb
  begin
    logic [32:0] sum;
    sum = 33'h0;
    nxt_st = st_ff;
    nxt_st.osc = 1'b0;
    nxt_st.smp = 1'b0;
    if (!run)
    begin
      nxt_st.acc = 32'h0;
      nxt_st.div = 9'h0;
    end
    else
    begin
      sum = {1'b0, st_ff.acc} + {1'b0, step};
      nxt_st.acc = sum[31:0];
      if (sum[32])
      begin
        nxt_st.osc = 1'b1;
        nxt_st.div = st_ff.div + 9'h1;
        if (st_ff.div == 9'h1FF)
          nxt_st.smp = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign osc_tick    = st_ff.osc;
  assign sample_tick = st_ff.smp;

endmodule : aosq_pacer

// file: test/aosq_host.sv
`timescale 1ns/10ps
////////////////////////////////////////
// Host side: Avalon master issuing commands and sample words
module aosq_host
(
  input  wire logic        sys_clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic [5:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  output logic             hang
);
  initial
  begin
    avs_address    = 6'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hF;
    hang           = 1'b0;
  end

  // Request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0)
      hang <= 1'b1;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : xfer
endmodule : aosq_host

// file: test/analog_output_sequencer_test.sv
`timescale 1ns/10ps
module analog_output_sequencer_test;
  localparam logic [31:0] C_GO  = 32'h1 << aosq_pkg::CTL_START;
  localparam logic [31:0] C_END = 32'h1 << aosq_pkg::CTL_ORDERLY;
  localparam logic [31:0] C_ABR = 32'h1 << aosq_pkg::CTL_ABRUPT;
  localparam logic [31:0] C_REP = 32'h1 << aosq_pkg::CTL_REPEAT;
  localparam logic [31:0] C_TRG = 32'h1 << aosq_pkg::CTL_EXTTRIG;
  localparam logic [31:0] C_CLR = 32'h1 << aosq_pkg::CTL_CLRERR;
  localparam logic [31:0] C_EXT = 32'h1 << aosq_pkg::CTL_EXTENDED;
  logic        sys_clk;
  logic        srst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_trig;
  logic        ai_running;
  logic [23:0] dac_code;
  logic        dac_osc;
  logic        dac_strobe;
  logic        hang;
  logic [31:0] seed;
  logic [31:0] rdata;
  logic [23:0] v;
  int          failures;
  int          check_count;
  int          osc_total;
  int          strobe_total;
  int          last_osc;
  int          last_cyc;
  int          cyc;
  int          run_id;
  int          seen_id;
  int          t0;
  int          s0;
  int          e;
  longint      tb_max;
  int          model_q[$];
  bit          rep;

  aosq_top dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_trig(ext_trig), .ai_running(ai_running),
    .dac_code(dac_code), .dac_osc(dac_osc), .dac_strobe(dac_strobe));
  aosq_host host (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .hang(hang));

  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  function logic [23:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[23:0];
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rdata);
  endtask : wr

  task automatic rd(input logic [5:0] a);
    host.xfer(1'b0, a, 32'h0, rdata);
  endtask : rd

  task automatic wait_strobes(input int n);
    int k;
    k = 0;
    while (strobe_total < n && k < 45000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (strobe_total < n)
    begin
      failures++;
      stop_test();
    end
  endtask : wait_strobes

  task automatic wait_idle();
    int k;
    k = 0;
    rd(aosq_pkg::REG_STATUS);
    while (rdata[2:0] !== 3'h0 && k < 2000)
    begin
      rd(aosq_pkg::REG_STATUS);
      k++;
    end
    if (rdata[2:0] !== 3'h0)
    begin
      failures++;
      stop_test();
    end
  endtask : wait_idle

  task automatic pulse_trig();
    @(posedge sys_clk);
    ext_trig <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    ext_trig <= 1'b0;
  endtask : pulse_trig
  ////////////////////////////////////////
  // Reference model: expected samples in order, wrapped when repeating
  always @(posedge sys_clk)
  begin
    cyc++;
    if (hang === 1'b1)
    begin
      failures++;
      stop_test();
    end
    if (dac_strobe === 1'b1)
    begin
      strobe_total++;
      if (model_q.size() == 0)
        chk({8'h00, dac_code}, 32'hFFFFFFFF);
      else
      begin
        e = model_q.pop_front();
        chk(dac_code, e);
        if (rep)
          model_q.push_back(e);
      end
      if (seen_id == run_id)
      begin
        chk(osc_total - last_osc, aosq_pkg::OSC_MULT);
        chk((cyc - last_cyc + 1) * tb_max >= 512 * longint'(aosq_pkg::SYS_CLK_HZ), 1);
      end
      seen_id  = run_id;
      last_osc = osc_total;
      last_cyc = cyc;
    end
    // Pulse in the strobe cycle opens the next period
    if (dac_osc === 1'b1)
      osc_total++;
  end
  ////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    srst = 1'b1;
    ext_trig = 1'b0;
    ai_running = 1'b0;
    seed = 32'h7D79;
    {failures, check_count, osc_total, strobe_total, cyc, run_id, seen_id} = '0;
    tb_max = aosq_pkg::BASE_TB_MAX_HZ;
    rep = 1'b0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    chk(dac_code, aosq_pkg::ZERO_VOLT_CODE);
    rd(aosq_pkg::REG_RATE);
    chk(rdata, aosq_pkg::BASE_RATE_HZ);
    rd(6'h20);
    chk(rdata, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 24'h000000 : (i == 1) ? 24'hFFFFFF : rnd();
      wr(aosq_pkg::REG_VALUE, {8'h00, v});
      @(posedge sys_clk);
      chk(dac_code, v);
      rd(aosq_pkg::REG_OUT);
      chk(rdata, v);
      wr(aosq_pkg::REG_CTRL, C_END);
      rd(aosq_pkg::REG_STATUS);
      chk(rdata[2:0], aosq_pkg::AOSQ_IDLE);
      chk(dac_code, v);
    end
    $display("test single done");
    ai_running <= 1'b1;
    wr(aosq_pkg::REG_LENGTH, 32'd3);
    wr(aosq_pkg::REG_CTRL, C_GO | C_REP);
    rd(aosq_pkg::REG_STATUS);
    chk({rdata[3], rdata[2:0]}, 4'h8);
    ai_running <= 1'b0;
    wr(aosq_pkg::REG_CTRL, C_CLR);
    wr(aosq_pkg::REG_LENGTH, 32'd8193);
    wr(aosq_pkg::REG_CTRL, C_GO | C_REP);
    rd(aosq_pkg::REG_STATUS);
    chk({rdata[4], rdata[2:0]}, 4'h8);
    wr(aosq_pkg::REG_LENGTH, 32'd3);
    wr(aosq_pkg::REG_CTRL, C_CLR);
    wr(aosq_pkg::REG_CTRL, C_GO);
    rd(aosq_pkg::REG_STATUS);
    chk({rdata[5], rdata[2:0]}, 4'h8);
    wr(aosq_pkg::REG_CTRL, C_CLR);
    rd(aosq_pkg::REG_STATUS);
    chk(rdata[6:3], 4'h0);
    $display("test errors done");
    for (int i = 0; i < 3; i++)
      wr(aosq_pkg::REG_DATA, {8'h00, rnd()});
    wr(aosq_pkg::REG_CTRL, C_GO | C_REP);
    rd(aosq_pkg::REG_STATUS);
    chk(rdata[2:0], aosq_pkg::AOSQ_LATENCY);
    wr(aosq_pkg::REG_CTRL, C_ABR);
    rd(aosq_pkg::REG_STATUS);
    chk({rdata[21:8], rdata[2:0]}, 32'h0);
    pulse_trig();
    rd(aosq_pkg::REG_STATUS);
    chk(rdata[2:0], aosq_pkg::AOSQ_IDLE);
    $display("test abrupt done");
    rep = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      v = rnd();
      model_q.push_back(v);
      wr(aosq_pkg::REG_DATA, {8'h00, v});
    end
    run_id++;
    t0 = osc_total;
    wr(aosq_pkg::REG_CTRL, C_GO | C_REP);
    wait_strobes(strobe_total + 1);
    t0 = last_osc - t0;
    chk(t0 > (aosq_pkg::BASE_LATENCY - 1) * 512 &&
        t0 <= (aosq_pkg::BASE_LATENCY + 1) * 512, 1);
    ai_running <= 1'b1;
    wait_strobes(strobe_total + 7);
    rd(aosq_pkg::REG_STATUS);
    chk(rdata[3], 1'b0);
    ai_running <= 1'b0;
    wr(aosq_pkg::REG_COUNT, 32'd2);
    s0 = strobe_total;
    wr(aosq_pkg::REG_CTRL, C_END | C_REP);
    wait_idle();
    chk(strobe_total - s0, 2);
    chk({rdata[7], rdata[6]}, 2'b10);
    model_q.delete();
    rep = 1'b0;
    pulse_trig();
    repeat (1200) @(posedge sys_clk);
    rd(aosq_pkg::REG_STATUS);
    chk(rdata[2:0], aosq_pkg::AOSQ_IDLE);
    $display("test waveform done");
    tb_max = aosq_pkg::EXT_TB_MAX_HZ;
    wr(aosq_pkg::REG_RATE, aosq_pkg::EXT_RATE_MAX_HZ);
    rd(aosq_pkg::REG_RATE);
    chk(rdata, aosq_pkg::EXT_RATE_MAX_HZ);
    for (int i = 0; i < 3; i++)
    begin
      v = rnd();
      model_q.push_back(v);
      wr(aosq_pkg::REG_DATA, {8'h00, v});
    end
    wr(aosq_pkg::REG_CTRL, C_GO | C_EXT | C_TRG);
    rd(aosq_pkg::REG_STATUS);
    chk(rdata[2:0], aosq_pkg::AOSQ_ARMED);
    run_id++;
    t0 = osc_total;
    pulse_trig();
    wait_strobes(strobe_total + 1);
    t0 = last_osc - t0;
    chk(t0 > (aosq_pkg::EXT_LATENCY - 1) * 512 &&
        t0 <= (aosq_pkg::EXT_LATENCY + 1) * 512, 1);
    for (int i = 0; i < 3; i++)
    begin
      v = rnd();
      model_q.push_back(v);
      wr(aosq_pkg::REG_DATA, {8'h00, v});
    end
    wait_strobes(strobe_total + 5);
    wait_idle();
    chk({rdata[21:8], rdata[6]}, 15'h1);
    $display("test continuous done");
    stop_test();
  end
endmodule : analog_output_sequencer_test
